// *** dram_host_ctrl.sv ***
// host controller driving a 64k x 4 dynamic memory through its strobes
// assumes one memory on the pins, user side on the same clock as clk_i
//
// Behaviour
// - for wider pages decode only column strobe, share the row strobe
// - page mode: row strobe held low, column cycles step through columns
// - each of 128 refresh rows refreshed at least once per 2 ms
// - refresh strobe low after precharge refreshes the internal counter row
// - row strobe idle in refresh-strobe cycles, and the reverse
// - hidden refresh: column strobe stays low through precharge and refresh
// - wait about 500 us and issue eight dummy cycles before accesses
`timescale 1ns/1ps
`include "dram_map.svh"

module dram_host_ctrl #(
    parameter int PWRUP_CYC = `PWRUP_CYC,
    parameter int REF_INTERVAL = `REF_INTERVAL_CYC,
    parameter int RCD_CYC = `RCD_CYC,
    parameter int CAS_CYC = `CAS_CYC,
    parameter int RP_CYC = `RP_CYC,
    parameter int RAS_REF_CYC = `RAS_REF_CYC,
    parameter int PAGE_MAX = `PAGE_MAX_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // user requests
    input wire logic req_valid_i,
    input wire dram_pkg::req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [3:0] rdata_o,
    // mode and status
    input wire logic ras_only_ref_i,
    input wire logic sleep_i,
    output logic init_done_o,
    output logic in_self_o,
    // memory pins
    output dram_pkg::pins_t pins_o,
    output logic [3:0] dq_o,
    output logic dq_oe_o,
    input wire logic [3:0] dq_i
);
    import dram_pkg::*;

    ctl_t q;
    ctl_t d;
    logic ref_due;
    logic [`REF_ROW_BITS-1:0] ref_row;
    logic row_hit;
    logic take;

    ////////////////////////////////////////////////////////////////////////
    // refresh spacing and host-side row counter
    refresh_pacer #(
        .INTERVAL(REF_INTERVAL)
    ) u_pacer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .adv_i(q.ref_pulse),
        .due_o(ref_due),
        .row_o(ref_row)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.ref_pulse = 1'b0;
        // two-stage sync of the data pins, only the second stage is read
        d.dq_s1 = dq_i;
        d.dq_s2 = q.dq_s1;
        take = req_valid_i & q.ready;
        row_hit = (req_i.addr[`ROW_POS +: `ROW_BITS] ==
                   q.req.addr[`ROW_POS +: `ROW_BITS]);
        case (q.st)
            st_powerup: begin
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'(PWRUP_CYC - 1)) begin
                    d.cnt = '0;
                    d.st = st_rref;
                    d.pin.ras_n = 1'b0;
                    d.pin.addr = {1'b0, ref_row};
                end
            end
            st_idle: begin
                if (take) begin
                    d.req = req_i;
                    d.pcnt = '0;
                    d.cnt = '0;
                    if (!q.pin.cas_n) begin
                        // held read data released before a new row opens
                        d.pin.cas_n = 1'b1;
                        d.pend = 1'b1;
                        d.st = st_pre;
                    end else begin
                        d.pin.ras_n = 1'b0;
                        d.pin.addr = req_i.addr[`ROW_POS +: `ROW_BITS];
                        d.st = st_row;
                    end
                end else if (ref_due) begin
                    d.cnt = '0;
                    if (ras_only_ref_i) begin
                        // cas left as is: low here means hidden refresh
                        d.pin.ras_n = 1'b0;
                        d.pin.addr = {1'b0, ref_row};
                        d.st = st_rref;
                    end else begin
                        d.pin.ref_n = 1'b0;
                        d.st = st_aref;
                    end
                end else if (sleep_i) begin
                    d.pin.ref_n = 1'b0;
                    d.self_on = 1'b1;
                    d.st = st_self;
                end
            end
            st_row: begin
                d.cnt = q.cnt + 16'h0001;
                d.pcnt = q.pcnt + 7'h01;
                if (q.cnt == 16'(RCD_CYC - 1)) begin
                    d.cnt = '0;
                    d.st = st_cas_hi;
                    d.pin.addr = q.req.addr[`COL_POS +: `COL_BITS];
                    d.pin.we_n = ~q.req.we;
                    d.dq = q.req.wdata;
                    d.dq_oe = q.req.we;
                end
            end
            st_cas_hi: begin
                // column and write strobe settle one cycle before cas falls
                d.pcnt = q.pcnt + 7'h01;
                d.pin.cas_n = 1'b0;
                d.cnt = '0;
                d.st = st_col;
            end
            st_col: begin
                d.cnt = q.cnt + 16'h0001;
                d.pcnt = q.pcnt + 7'h01;
                if (q.cnt == 16'(CAS_CYC - 1)) begin
                    d.done = 1'b1;
                    if (!q.req.we) begin
                        d.rdata = q.dq_s2;
                    end
                    // after a read cas stays low so the data stays on the pins
                    d.pin.cas_n = q.req.we;
                    d.pin.we_n = `STROBE_IDLE;
                    d.dq_oe = 1'b0;
                    d.st = st_open;
                end
            end
            st_open: begin
                d.pcnt = q.pcnt + 7'h01;
                if (take && row_hit) begin
                    // same row: new column only, row stays latched
                    d.req = req_i;
                    d.pin.cas_n = 1'b1;
                    d.pin.addr = req_i.addr[`COL_POS +: `COL_BITS];
                    d.pin.we_n = ~req_i.we;
                    d.dq = req_i.wdata;
                    d.dq_oe = req_i.we;
                    d.st = st_cas_hi;
                end else if (take) begin
                    d.req = req_i;
                    d.pend = 1'b1;
                    d.pin.ras_n = 1'b1;
                    d.pin.cas_n = 1'b1;
                    d.cnt = '0;
                    d.st = st_pre;
                end else if (ref_due || q.pcnt >= 7'(PAGE_MAX)) begin
                    // cas untouched so a held read stays valid
                    d.pin.ras_n = 1'b1;
                    d.cnt = '0;
                    d.st = st_pre;
                end
            end
            st_pre: begin
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'(RP_CYC - 1)) begin
                    d.cnt = '0;
                    if (!q.init_done && q.dcnt != 4'(`DUMMY_CYCLES)) begin
                        d.pin.ras_n = 1'b0;
                        d.pin.addr = {1'b0, ref_row};
                        d.st = st_rref;
                    end else if (q.pend) begin
                        d.pend = 1'b0;
                        d.pcnt = '0;
                        d.pin.ras_n = 1'b0;
                        d.pin.addr = q.req.addr[`ROW_POS +: `ROW_BITS];
                        d.st = st_row;
                    end else begin
                        d.init_done = 1'b1;
                        d.st = st_idle;
                    end
                end
            end
            st_rref: begin
                // ref_n stays high for the whole row-strobe cycle
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'(RAS_REF_CYC - 1)) begin
                    d.cnt = '0;
                    d.pin.ras_n = 1'b1;
                    d.ref_pulse = 1'b1;
                    if (!q.init_done) begin
                        d.dcnt = q.dcnt + 4'h1;
                    end
                    d.st = st_pre;
                end
            end
            st_aref: begin
                // ras_n stays high for the whole refresh-strobe cycle
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == 16'(RAS_REF_CYC - 1)) begin
                    d.cnt = '0;
                    d.pin.ref_n = `STROBE_IDLE;
                    d.ref_pulse = 1'b1;
                    d.st = st_pre;
                end
            end
            st_self: begin
                // device keeps its own timer here, pacer ticks on regardless
                if (!sleep_i) begin
                    d.pin.ref_n = `STROBE_IDLE;
                    d.self_on = 1'b0;
                    d.cnt = '0;
                    d.st = st_pre;
                end
            end
            default: begin
                d.st = st_idle;
            end
        endcase
        // no access is offered while a refresh waits or the page runs long
        d.ready = d.init_done & ~take &
                  ((d.st == st_idle & ~ref_due & ~sleep_i) |
                   (d.st == st_open & ~ref_due &
                    d.pcnt < 7'(PAGE_MAX - 1)));
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, strobes idle high from reset on
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.pin.ras_n <= `STROBE_IDLE;
            q.pin.cas_n <= `STROBE_IDLE;
            q.pin.we_n <= `STROBE_IDLE;
            q.pin.ref_n <= `STROBE_IDLE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign req_ready_o = q.ready;
    assign done_o = q.done;
    assign rdata_o = q.rdata;
    assign init_done_o = q.init_done;
    assign in_self_o = q.self_on;
    assign pins_o = q.pin;
    assign dq_o = q.dq;
    assign dq_oe_o = q.dq_oe;

endmodule // dram_host_ctrl

// *** dram_map.svh ***
// timing counts, field positions and reset levels for the dram host
// assumes a 10 MHz controller clock; included by bare name
`ifndef DRAM_MAP_SVH
`define DRAM_MAP_SVH

`define CLK_PERIOD_NS 100
// power-up wait, least time, rounded up
`define PWRUP_US 500
`define PWRUP_CYC ((`PWRUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DUMMY_CYCLES 8
// retention window spread over all refresh rows, longest time, rounded down
`define REF_WINDOW_MS 2
`define REF_ROWS 128
`define REF_INTERVAL_CYC ((`REF_WINDOW_MS * 1000000) / (`REF_ROWS * `CLK_PERIOD_NS))
// address layout of the user word and the pins
`define ROW_BITS 8
`define COL_BITS 8
`define REF_ROW_BITS 7
`define ROW_POS 8
`define COL_POS 0
// cycle counts of strobe phases, plain defaults
`define RCD_CYC 2
`define CAS_CYC 4
`define RP_CYC 2
`define RAS_REF_CYC 3
`define PAGE_MAX_CYC 90
// idle level of every strobe
`define STROBE_IDLE 1'b1

`endif

// *** dram_pkg.sv ***
// types shared by the dram host controller and its refresh pacer
// assumes dram_map.svh sits in the include path
`include "dram_map.svh"

package dram_pkg;

    // controller states, gray along idle-row-cas_hi-col-open-pre
    typedef enum logic [3:0] {
        st_powerup = 4'h0,
        st_idle = 4'h1,
        st_row = 4'h3,
        st_cas_hi = 4'h2,
        st_col = 4'h6,
        st_open = 4'h7,
        st_pre = 4'h5,
        st_rref = 4'h4,
        st_aref = 4'hc,
        st_self = 4'hd
    } state_t;

    // strobes and multiplexed address toward the memory
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic ref_n;
        logic [`ROW_BITS-1:0] addr;
    } pins_t;

    // one user access
    typedef struct packed {
        logic we;
        logic [`ROW_BITS+`COL_BITS-1:0] addr;
        logic [3:0] wdata;
    } req_t;

    // whole state of the controller
    typedef struct packed {
        state_t st;
        pins_t pin;
        logic [3:0] dq;
        logic dq_oe;
        logic [15:0] cnt;
        logic [6:0] pcnt;
        logic [3:0] dcnt;
        logic init_done;
        logic pend;
        req_t req;
        logic ready;
        logic done;
        logic [3:0] rdata;
        logic self_on;
        logic ref_pulse;
        logic [3:0] dq_s1;
        logic [3:0] dq_s2;
    } ctl_t;

    // whole state of the refresh pacer
    typedef struct packed {
        logic [15:0] tick;
        logic due;
        logic [`REF_ROW_BITS-1:0] row;
    } pacer_t;

endpackage

// *** refresh_pacer.sv ***
// refresh pacer: spaces refresh requests and keeps the refresh row
// assumes adv_i pulses once per refresh cycle the controller finishes
`timescale 1ns/1ps
`include "dram_map.svh"

module refresh_pacer #(
    parameter int INTERVAL = `REF_INTERVAL_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // refresh handshake
    input wire logic adv_i,
    output logic due_o,
    output logic [`REF_ROW_BITS-1:0] row_o
);
    import dram_pkg::*;

    pacer_t q;
    pacer_t d;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    // one request per interval, row counter steps per refresh
    always_comb begin
        d = q;
        hit = (q.tick == 16'(INTERVAL - 1));
        d.tick = hit ? 16'h0000 : q.tick + 16'h0001;
        if (adv_i) begin
            d.row = q.row + 7'h01;
        end
        // a new interval arriving with the ack keeps the request up
        d.due = hit | (q.due & ~adv_i);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign due_o = q.due;
    assign row_o = q.row;

endmodule // refresh_pacer

// *** dram_host_ctrl_chk.sv ***
// checker for the dram host controller, sees its ports only
// assumes bind onto dram_host_ctrl, one clock, synchronous reset
`timescale 1ns/1ps
module dram_host_ctrl_chk import dram_pkg::*; #(
    parameter int PWRUP_CYC = 5000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // user side
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic done_o,
    input wire logic init_done_o,
    input wire logic in_self_o,
    // memory pins
    input wire dram_pkg::pins_t pins_o,
    input wire logic dq_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [15:0] wait_q;
    logic [3:0] dummies_q;
    // cycles since release, row strobe falls before init
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wait_q <= 16'h0000;
            dummies_q <= 4'h0;
        end else begin
            if (wait_q != 16'hffff) wait_q <= wait_q + 16'h0001;
            if (!init_done_o && $fell(pins_o.ras_n))
                dummies_q <= dummies_q + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    // reset cannot be its own disable, so this one has none
    a_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
        !resetn_i |=> pins_o.ras_n && pins_o.cas_n && pins_o.ref_n
        && !dq_oe_o && !req_ready_o && !done_o)
        else $error("pins not idle after reset");
    a_ref_ras_excl: assert property (!(!pins_o.ras_n && !pins_o.ref_n))
        else $error("row and refresh strobe low together");
    a_take_drops: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
        else $error("ready stayed high after a take");
    a_take_done: assert property (req_valid_i && req_ready_o |-> ##[5:24] done_o)
        else $error("no done within bound of a take");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_ready_init: assert property (req_ready_o |-> init_done_o)
        else $error("ready before init done");
    a_pwrup_wait: assert property ($fell(pins_o.ras_n) && !init_done_o
        |-> wait_q >= 16'(PWRUP_CYC - 1))
        else $error("row strobe before power-up wait");
    a_dummy_count: assert property ($rose(init_done_o) |-> dummies_q == 4'h8)
        else $error("init done without eight dummy cycles");
    a_self_pins: assert property (in_self_o |-> pins_o.ras_n && !pins_o.ref_n)
        else $error("self-refresh pins wrong");
    a_cas_in_row: assert property ($fell(pins_o.cas_n) |-> !pins_o.ras_n)
        else $error("column strobe fell without row strobe");
    a_early_write: assert property ($fell(pins_o.cas_n) && !pins_o.we_n
        |-> !$past(pins_o.we_n) && dq_oe_o)
        else $error("write strobe not ahead of column strobe");
    a_oe_write: assert property (dq_oe_o |-> !pins_o.we_n && !pins_o.ras_n)
        else $error("data driven outside a write");
endmodule // dram_host_ctrl_chk

bind dram_host_ctrl dram_host_ctrl_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .init_done_o(init_done_o),
    .in_self_o(in_self_o), .pins_o(pins_o), .dq_oe_o(dq_oe_o));

// *** dram_dev_model.sv ***
// behavioural model of the 64k x 4 dynamic memory on the host pins
// assumes strobes from registered host outputs; no clock of its own
`timescale 1ns/1ps
module dram_dev_model import dram_pkg::*; (
    // memory pins
    input wire dram_pkg::pins_t pins_i,
    input wire logic [3:0] d_i,
    output logic [3:0] q_o,
    // observation
    output logic [6:0] ref_row_o,
    output logic [7:0] page_hits_o,
    output logic err_o
);
    logic [3:0] mem [0:65535];
    logic [7:0] row_q;
    logic [7:0] col_q;
    logic [3:0] qd;
    logic drv;
    logic fresh;
    int low_us;
    wire ref_w = (pins_i.ref_n === 1'b0) ? 1'b0 : 1'b1;
    initial begin
        drv = 1'b0;
        qd = 4'h0;
        fresh = 1'b0;
        low_us = 0;
        page_hits_o = 8'h00;
        err_o = 1'b0;
        ref_row_o = 7'h00;
    end
    ////////////////////////////////////////////////////////////
    // row latch refreshes the row; overlap with refresh is a fault
    always @(negedge pins_i.ras_n) begin
        row_q = pins_i.addr;
        fresh = 1'b1;
        if (!ref_w) err_o = 1'b1;
    end
    // column latch only under a low row strobe, else standby
    always @(negedge pins_i.cas_n) begin
        if (!pins_i.ras_n) begin
            col_q = pins_i.addr;
            if (!fresh) page_hits_o = page_hits_o + 8'h01;
            fresh = 1'b0;
            if (!pins_i.we_n) mem[{row_q, col_q}] = d_i;
            else begin
                qd = mem[{row_q, col_q}];
                drv = 1'b1;
            end
        end
    end
    // outputs follow the column strobe only, held through hidden refresh
    always @(posedge pins_i.cas_n) drv = 1'b0;
    // floating bus shows the inverse so a stale value never passes
    assign q_o = drv ? qd : ~qd;
    // internal counter steps at the end of each refresh-pin cycle
    always @(posedge ref_w) if (pins_i.ras_n) ref_row_o = ref_row_o + 7'h01;
    // self-refresh timer: one row per 14 us of unbroken low refresh pin,
    // so short refresh-pin cycles never count as self-refresh steps
    always begin
        #1000;
        if (ref_w) low_us = 0;
        else low_us = low_us + 1;
        if (low_us == 14) begin
            low_us = 0;
            if (pins_i.ras_n) ref_row_o = ref_row_o + 7'h01;
        end
    end
endmodule // dram_dev_model

// *** tb_dram_refresh_and_page_control.sv ***
// self-checking bench for the dram host controller and a memory model
// assumes dram_map.svh in the include path, checker bound by itself
`timescale 1ns/1ps
`include "dram_map.svh"
module tb_dram_refresh_and_page_control;
    import dram_pkg::*;
    localparam int PWR = 20;
    localparam int RIV = 40;
    typedef struct packed {logic we; logic [15:0] a; logic [3:0] d;} case_t;
    logic clk_i = 0, resetn_i = 0, req_valid_i = 0, ras_only_ref_i = 1;
    logic sleep_i = 0, req_ready_o, done_o, init_done_o, in_self_o, dq_oe_o;
    logic err, mon_on = 0, ras_d = 1, ref_d = 1;
    logic [3:0] rdata_o, dq_o, dq_i;
    logic [6:0] ref_row;
    logic [7:0] hits, last_a = 8'h00;
    req_t req_i = '0;
    pins_t pins_o;
    int mismatches = 0, checks = 0, cyc = 0, ras_falls = 0, ref_falls = 0;
    case_t rows [12] = '{'{1, 16'h1234, 4'ha}, '{1, 16'h1235, 4'h5},
        '{1, 16'h8000, 4'h3}, '{1, 16'hffff, 4'hc}, '{1, 16'h00ff, 4'h6},
        '{0, 16'h1234, 4'ha}, '{0, 16'h1235, 4'h5}, '{0, 16'h8000, 4'h3},
        '{0, 16'h00ff, 4'h6}, '{0, 16'hffff, 4'hc}, '{1, 16'hffff, 4'h9},
        '{0, 16'hffff, 4'h9}};
    always #50 clk_i = ~clk_i;
    dram_host_ctrl #(.PWRUP_CYC(PWR), .REF_INTERVAL(RIV)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
        .rdata_o(rdata_o), .ras_only_ref_i(ras_only_ref_i), .sleep_i(sleep_i),
        .init_done_o(init_done_o), .in_self_o(in_self_o), .pins_o(pins_o),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
    dram_dev_model mem_m (.pins_i(pins_o), .d_i(dq_o), .q_o(dq_i),
        .ref_row_o(ref_row), .page_hits_o(hits), .err_o(err));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // request held until an edge sees ready, answer taken with done
    task automatic access(input logic we, input logic [15:0] a,
            input logic [3:0] wd, output logic [3:0] rd);
        int n = 0;
        req_valid_i <= 1'b1;
        req_i <= '{we: we, addr: a, wdata: wd};
        do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 300);
        req_valid_i <= 1'b0;
        do @(posedge clk_i); while (done_o !== 1'b1 && ++n < 300);
        rd = rdata_o;
        if (n >= 300) chk("access wait", 8'h00, 8'h01);
    endtask
    // reset held 3 cycles, then wait out power-up and dummies
    task automatic do_reset();
        int n = 0;
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("reset pins", 8'h38, {2'b00, pins_o.ras_n, pins_o.cas_n,
            pins_o.ref_n, dq_oe_o, req_ready_o, init_done_o});
        resetn_i <= 1'b1;
        while (init_done_o !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        chk("init time", 8'h01, 8'(n >= PWR + 8 * `RAS_REF_CYC));
    endtask
    task automatic wait_ref_end();
        int n = 0;
        while (pins_o.ref_n !== 1'b0 && n < 200) begin @(posedge clk_i); n++; end
        while (pins_o.ref_n !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
    endtask
    // cycle ceiling, several times the expected run; nothing after the report
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            mismatches++;
            final_report();
        end
    end
    // refresh monitor over an idle window, host row must step by one
    always @(posedge clk_i) begin
        ras_d <= pins_o.ras_n;
        ref_d <= pins_o.ref_n;
        if (mon_on && ras_d && !pins_o.ras_n) begin
            if (ras_falls > 0) chk("refresh row", (last_a + 8'h01) & 8'h7f, pins_o.addr);
            last_a <= pins_o.addr;
            ras_falls <= ras_falls + 1;
        end
        if (mon_on && ref_d && !pins_o.ref_n) ref_falls <= ref_falls + 1;
    end
    initial begin
        logic [3:0] rd;
        logic [6:0] r0;
        logic [7:0] h;
        int n;
        do_reset();
        foreach (rows[i]) begin
            access(rows[i].we, rows[i].a, rows[i].d, rd);
            if (!rows[i].we) chk("read data", {4'h0, rows[i].d}, {4'h0, rd});
        end
        mon_on <= 1'b1;
        repeat (10 * RIV) @(posedge clk_i);
        mon_on <= 1'b0;
        chk("row refreshes", 8'h01, 8'(ras_falls >= 9));
        chk("hidden cas", 8'h00, {7'h00, pins_o.cas_n});
        chk("hidden data", 8'h09, {4'h0, dq_i});
        ras_only_ref_i <= 1'b0;
        wait_ref_end();
        n = ras_falls;
        r0 = ref_row;
        mon_on <= 1'b1;
        repeat (10 * RIV) @(posedge clk_i);
        mon_on <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("pin refreshes", 8'h01, 8'(ref_falls >= 9));
        chk("row idle in pin mode", 8'(n), 8'(ras_falls));
        chk("counter steps", 8'(ref_falls), {1'b0, 7'(ref_row - r0)});
        wait_ref_end();
        h = hits;
        access(1'b1, 16'h4401, 4'h1, rd);
        access(1'b0, 16'h4401, 4'h0, rd);
        chk("page data", 8'h01, {4'h0, rd});
        chk("page hit", h + 8'h01, hits);
        sleep_i <= 1'b1;
        n = 0;
        while (in_self_o !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
        chk("self entry", 8'h01, {7'h00, in_self_o});
        r0 = ref_row;
        repeat (300) @(posedge clk_i);
        chk("self steps", 8'h01, 8'(7'(ref_row - r0) >= 7'h02));
        sleep_i <= 1'b0;
        access(1'b0, 16'hffff, 4'h0, rd);
        chk("after self", 8'h09, {4'h0, rd});
        do_reset();
        access(1'b0, 16'h1235, 4'h0, rd);
        chk("after reset", 8'h05, {4'h0, rd});
        chk("strobe overlap", 8'h00, {7'h00, err});
        final_report();
    end
endmodule // tb_dram_refresh_and_page_control
